//--- hdl/ocia_consts.svh
// Constants of the interrupt aggregator: register offsets, resets, group indices.
// Assumes inclusion by bare name from package and design files.
`ifndef OCIA_CONSTS_SVH
`define OCIA_CONSTS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OCIA_OFF_CTRL 8'h00
`define OCIA_OFF_DB_CTRL 8'h04
`define OCIA_OFF_PIN0 8'h08
`define OCIA_OFF_PIN4 8'h18
`define OCIA_OFF_DB_STS0 8'h20
`define OCIA_OFF_DB_STS7 8'h3C
`define OCIA_OFF_ENG_ROUTE0 8'h40
`define OCIA_OFF_ENG_ROUTE1 8'h44
`define OCIA_OFF_ENG_STS0 8'h48
`define OCIA_OFF_ENG_STS1 8'h4C
`define OCIA_OFF_DMA_IIR 8'h50
`define OCIA_OFF_CSF_PORT0 8'h60
`define OCIA_OFF_CSF_PORT3 8'h6C
`define OCIA_OFF_CSF_STAT0 8'h70
`define OCIA_OFF_CSF_STAT3 8'h7C
`define OCIA_OFF_IRQ_STS 8'h80
`define OCIA_OFF_IRQ_CLR 8'h84
`define OCIA_OFF_IRQ_EN 8'h88
// ****************************************
// Field positions and reset values
// ****************************************
`define OCIA_BIT_CORE_READY 0
`define OCIA_BIT_ROUTE_CPU 31
`define OCIA_PIN_W 5
`define OCIA_PIN_STRIDE 8
`define OCIA_PIN_PER_REG 4
`define OCIA_PIN_RESET 5'h1F
`define OCIA_NUM_GROUPS 17
`define OCIA_NUM_LINES 28
`define OCIA_LINE_BASE 4
`define OCIA_NUM_DB 8
`define OCIA_NUM_CSF 4
// ****************************************
// Group indices
// ****************************************
`define OCIA_GRP_DB0 0
`define OCIA_GRP_SEM 8
`define OCIA_GRP_DISP 9
`define OCIA_GRP_ENG0 10
`define OCIA_GRP_ENG1 11
`define OCIA_GRP_DMA 12
`define OCIA_GRP_HOST_PF 13
`define OCIA_GRP_HOST_VF0 14
`define OCIA_GRP_HOST_VF1 15
`define OCIA_GRP_IOMMU 16
`endif

//--- hdl/ocia_irq_aggregator.sv
// Interrupt aggregator for an embedded scheduling core, APB register slave.
// Assumes one 100 MHz clock, synchronous inputs, event inputs as one-cycle pulses.
// Function
// - Core bits 0 to 3 belong to the core itself and are never driven by the aggregator.
// - External line n drives core bit n+4, whose priority level is fixed inside the core.
// - Until firmware sets core ready, requests are held and accumulated, then all delivered.
// - Each of the 17 groups has its own pin field selecting its external line.
// - Groups sharing a line are ORed onto it.
// - Every pin field resets to 1F, which drives no line.
// - Group indices are fixed: doorbells 0-7, semaphore 8, display 9, engines 10-11, DMA 12, host 13-15, IOMMU 16.
// - A rung flag sets when its doorbell group goes from all zeros to any bit set; here it sets on each db_rung_set_i pulse instead.
// - A set rung flag holds until its doorbell group status is read, which clears it.
// - A routing bit, reset to host, steers doorbell interrupts to the embedded core when set.
// - Per engine word and cause, software chooses core delivery or direct forwarding to host.
// - A context-status port returns one 64-bit entry over two reads, low word first.
// - Each of the four context-status FIFOs has a read-only status register.
// - DMA transfer completion sets the DMA interrupt input register.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ocia_consts.svh"
module ocia_irq_aggregator
    import ocia_pkg::*;
#(
    parameter int CSF_DEPTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [`OCIA_NUM_DB-1:0][31:0] db_group_bits_i,
    input wire logic [`OCIA_NUM_DB-1:0] db_rung_set_i,
    input wire logic [1:0][31:0] eng_evt_i,
    input wire logic dma_done_i,
    input wire logic [5:0] ext_grp_i,
    input wire logic [`OCIA_NUM_CSF-1:0] csf_push_i,
    input wire logic [`OCIA_NUM_CSF-1:0][63:0] csf_data_i,
    output logic [31:0] core_irq_o,
    output logic db_host_irq_o,
    output logic [1:0][31:0] eng_host_evt_o,
    output logic irq_o
);
    localparam int AW = $clog2(CSF_DEPTH);
    initial begin
        if (CSF_DEPTH < 2 || CSF_DEPTH > 16 || (1 << AW) != CSF_DEPTH) begin
            $error("CSF_DEPTH must be a power of two from 2 to 16");
        end
    end
    // ****************************************
    // State
    // ****************************************
    logic ready, next_ready;
    logic route, next_route;
    logic [`OCIA_NUM_GROUPS-1:0][4:0] pin, next_pin;
    logic [`OCIA_NUM_DB-1:0] rung, next_rung;
    logic [1:0][31:0] eng_route, next_eng_route;
    logic [1:0][31:0] eng_sts, next_eng_sts;
    logic [1:0][31:0] next_eng_host;
    logic [31:0] dma_iir, next_dma_iir;
    logic [`OCIA_NUM_GROUPS-1:0] irq_sts, next_irq_sts, irq_en, next_irq_en, grp_req;
    logic [31:0] next_core, next_prdata;
    logic next_pready, next_pslverr, next_db_host, next_irq;
    logic [`OCIA_NUM_DB-1:0] db_clr;
    logic [63:0] csf_mem [`OCIA_NUM_CSF][CSF_DEPTH];
    logic [`OCIA_NUM_CSF-1:0][AW-1:0] rd_ptr, next_rd_ptr, wr_ptr, next_wr_ptr;
    logic [`OCIA_NUM_CSF-1:0][4:0] cnt, next_cnt;
    logic [`OCIA_NUM_CSF-1:0] ovf, next_ovf, push_ok;
    ocia_half_t [`OCIA_NUM_CSF-1:0] half, next_half;
    logic wr_acc, rd_acc, setup;
    logic [`OCIA_NUM_LINES-1:0] lines;

    // Group request sources in fixed index order
    always_comb begin
        grp_req = '0;
        grp_req[`OCIA_GRP_DB0 +: `OCIA_NUM_DB] = route ? rung : '0;
        grp_req[`OCIA_GRP_SEM] = ext_grp_i[0];
        grp_req[`OCIA_GRP_DISP] = ext_grp_i[1];
        grp_req[`OCIA_GRP_ENG0] = |eng_sts[0];
        grp_req[`OCIA_GRP_ENG1] = |eng_sts[1];
        grp_req[`OCIA_GRP_DMA] = |dma_iir;
        grp_req[`OCIA_GRP_HOST_PF] = ext_grp_i[2];
        grp_req[`OCIA_GRP_HOST_VF0] = ext_grp_i[3];
        grp_req[`OCIA_GRP_HOST_VF1] = ext_grp_i[4];
        grp_req[`OCIA_GRP_IOMMU] = ext_grp_i[5];
    end

    // Line map: OR of all pending groups whose field names the line
    always_comb begin
        lines = '0;
        for (int n = 0; n < `OCIA_NUM_LINES; n++) begin
            for (int g = 0; g < `OCIA_NUM_GROUPS; g++) begin
                if (irq_sts[g] && pin[g] == 5'(n)) begin
                    lines[n] = 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        next_ready = ready;
        next_route = route;
        next_pin = pin;
        next_rung = rung;
        next_eng_route = eng_route;
        next_eng_sts = eng_sts;
        next_dma_iir = dma_iir;
        next_irq_en = irq_en;
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        next_cnt = cnt;
        next_ovf = ovf;
        next_half = half;
        next_prdata = prdata_o;
        next_pslverr = pslverr_o;
        db_clr = '0;
        push_ok = '0;
        setup = psel_i & ~penable_i;
        wr_acc = psel_i & penable_i & pready_o & pwrite_i;
        rd_acc = psel_i & penable_i & pready_o & ~pwrite_i;
        next_pready = setup; // One wait-free access phase after each setup
        // Read data and error decoded in the setup cycle
        if (setup) begin
            next_prdata = 32'h0000_0000;
            next_pslverr = 1'b0;
            if (paddr_i[1:0] != 2'h0) begin
                next_pslverr = 1'b1;
            end else if (paddr_i == `OCIA_OFF_CTRL) begin
                next_prdata[`OCIA_BIT_CORE_READY] = ready;
            end else if (paddr_i == `OCIA_OFF_DB_CTRL) begin
                next_prdata[`OCIA_NUM_DB-1:0] = rung;
                next_prdata[`OCIA_BIT_ROUTE_CPU] = route;
            end else if (paddr_i >= `OCIA_OFF_PIN0 && paddr_i <= `OCIA_OFF_PIN4) begin
                for (int j = 0; j < `OCIA_PIN_PER_REG; j++) begin
                    if (int'(paddr_i[4:2]) * `OCIA_PIN_PER_REG + j - 2 * `OCIA_PIN_PER_REG
                        < `OCIA_NUM_GROUPS) begin
                        next_prdata[j*`OCIA_PIN_STRIDE +: `OCIA_PIN_W] =
                            pin[int'(paddr_i[4:2]) * `OCIA_PIN_PER_REG + j
                                - 2 * `OCIA_PIN_PER_REG];
                    end
                end
            end else if (paddr_i >= `OCIA_OFF_DB_STS0 && paddr_i <= `OCIA_OFF_DB_STS7) begin
                next_prdata = db_group_bits_i[paddr_i[4:2]];
            end else if (paddr_i == `OCIA_OFF_ENG_ROUTE0 || paddr_i == `OCIA_OFF_ENG_ROUTE1) begin
                next_prdata = eng_route[paddr_i[2]];
            end else if (paddr_i == `OCIA_OFF_ENG_STS0 || paddr_i == `OCIA_OFF_ENG_STS1) begin
                next_prdata = eng_sts[paddr_i[2]];
            end else if (paddr_i == `OCIA_OFF_DMA_IIR) begin
                next_prdata = dma_iir;
            end else if (paddr_i >= `OCIA_OFF_CSF_PORT0 && paddr_i <= `OCIA_OFF_CSF_PORT3) begin
                if (cnt[paddr_i[3:2]] != 5'h00) begin
                    next_prdata = (half[paddr_i[3:2]] == OCIA_HALF_HIGH) ?
                        csf_mem[paddr_i[3:2]][rd_ptr[paddr_i[3:2]]][63:32] :
                        csf_mem[paddr_i[3:2]][rd_ptr[paddr_i[3:2]]][31:0];
                end
            end else if (paddr_i >= `OCIA_OFF_CSF_STAT0 && paddr_i <= `OCIA_OFF_CSF_STAT3) begin
                next_prdata[$bits(ocia_csf_stat_t)-1:0] = ocia_csf_stat_t'({ovf[paddr_i[3:2]],
                    cnt[paddr_i[3:2]] == 5'(CSF_DEPTH), cnt[paddr_i[3:2]] == 5'h00,
                    cnt[paddr_i[3:2]]});
            end else if (paddr_i == `OCIA_OFF_IRQ_STS) begin
                next_prdata[`OCIA_NUM_GROUPS-1:0] = irq_sts;
            end else if (paddr_i == `OCIA_OFF_IRQ_EN) begin
                next_prdata[`OCIA_NUM_GROUPS-1:0] = irq_en;
            end else if (paddr_i != `OCIA_OFF_IRQ_CLR) begin
                next_pslverr = 1'b1;
            end
        end
        // Register writes at the completing edge
        if (wr_acc && !pslverr_o) begin
            if (paddr_i == `OCIA_OFF_CTRL) begin
                next_ready = pwdata_i[`OCIA_BIT_CORE_READY];
            end else if (paddr_i == `OCIA_OFF_DB_CTRL) begin
                next_route = pwdata_i[`OCIA_BIT_ROUTE_CPU];
            end else if (paddr_i >= `OCIA_OFF_PIN0 && paddr_i <= `OCIA_OFF_PIN4) begin
                for (int j = 0; j < `OCIA_PIN_PER_REG; j++) begin
                    if (int'(paddr_i[4:2]) * `OCIA_PIN_PER_REG + j - 2 * `OCIA_PIN_PER_REG
                        < `OCIA_NUM_GROUPS) begin
                        next_pin[int'(paddr_i[4:2]) * `OCIA_PIN_PER_REG + j
                            - 2 * `OCIA_PIN_PER_REG] =
                            pwdata_i[j*`OCIA_PIN_STRIDE +: `OCIA_PIN_W];
                    end
                end
            end else if (paddr_i == `OCIA_OFF_ENG_ROUTE0 || paddr_i == `OCIA_OFF_ENG_ROUTE1) begin
                next_eng_route[paddr_i[2]] = pwdata_i;
            end else if (paddr_i == `OCIA_OFF_ENG_STS0 || paddr_i == `OCIA_OFF_ENG_STS1) begin
                next_eng_sts[paddr_i[2]] = eng_sts[paddr_i[2]] & ~pwdata_i;
            end else if (paddr_i == `OCIA_OFF_DMA_IIR) begin
                next_dma_iir = dma_iir & ~pwdata_i;
            end else if (paddr_i == `OCIA_OFF_IRQ_EN) begin
                next_irq_en = pwdata_i[`OCIA_NUM_GROUPS-1:0];
            end
        end
        // Read side effects at the completing edge
        if (rd_acc && !pslverr_o) begin
            if (paddr_i >= `OCIA_OFF_DB_STS0 && paddr_i <= `OCIA_OFF_DB_STS7) begin
                db_clr[paddr_i[4:2]] = 1'b1;
            end else if (paddr_i >= `OCIA_OFF_CSF_PORT0 && paddr_i <= `OCIA_OFF_CSF_PORT3
                && cnt[paddr_i[3:2]] != 5'h00) begin
                if (half[paddr_i[3:2]] == OCIA_HALF_HIGH) begin
                    next_half[paddr_i[3:2]] = OCIA_HALF_LOW;
                    next_rd_ptr[paddr_i[3:2]] = rd_ptr[paddr_i[3:2]] + 1'b1;
                    next_cnt[paddr_i[3:2]] = cnt[paddr_i[3:2]] - 5'h01;
                end else begin
                    next_half[paddr_i[3:2]] = OCIA_HALF_HIGH;
                end
            end else if (paddr_i >= `OCIA_OFF_CSF_STAT0 && paddr_i <= `OCIA_OFF_CSF_STAT3) begin
                next_ovf[paddr_i[3:2]] = 1'b0;
            end
        end
        // Hardware events win over clears in the same cycle
        next_rung = (rung & ~db_clr) | db_rung_set_i;
        for (int e = 0; e < 2; e++) begin
            next_eng_sts[e] = next_eng_sts[e] | (eng_evt_i[e] & eng_route[e]);
            next_eng_host[e] = eng_evt_i[e] & ~eng_route[e];
        end
        next_dma_iir[0] = next_dma_iir[0] | dma_done_i;
        // FIFO pushes; a push to a full FIFO is dropped and flagged
        for (int k = 0; k < `OCIA_NUM_CSF; k++) begin
            if (csf_push_i[k]) begin
                if (cnt[k] == 5'(CSF_DEPTH)) begin
                    next_ovf[k] = 1'b1;
                end else begin
                    push_ok[k] = 1'b1;
                    next_wr_ptr[k] = wr_ptr[k] + 1'b1;
                    next_cnt[k] = next_cnt[k] + 5'h01;
                end
            end
        end
        // Accumulate group requests; the clear register loses to a new request
        next_irq_sts = irq_sts | grp_req;
        if (wr_acc && !pslverr_o && paddr_i == `OCIA_OFF_IRQ_CLR) begin
            next_irq_sts = (irq_sts & ~pwdata_i[`OCIA_NUM_GROUPS-1:0]) | grp_req;
        end
        next_core = ready ? {lines, 4'h0} : 32'h0000_0000;
        next_db_host = ~route & |rung;
        next_irq = |(irq_sts & irq_en);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ready <= 1'b0;
            route <= 1'b0;
            pin <= {`OCIA_NUM_GROUPS{`OCIA_PIN_RESET}};
            rung <= '0;
            eng_route <= '0;
            eng_sts <= '0;
            dma_iir <= 32'h0000_0000;
            irq_sts <= '0;
            irq_en <= '0;
            rd_ptr <= '0;
            wr_ptr <= '0;
            cnt <= '0;
            ovf <= '0;
            half <= {`OCIA_NUM_CSF{OCIA_HALF_LOW}};
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            core_irq_o <= 32'h0000_0000;
            db_host_irq_o <= 1'b0;
            eng_host_evt_o <= '0;
            irq_o <= 1'b0;
        end else begin
            ready <= next_ready;
            route <= next_route;
            pin <= next_pin;
            rung <= next_rung;
            eng_route <= next_eng_route;
            eng_sts <= next_eng_sts;
            dma_iir <= next_dma_iir;
            irq_sts <= next_irq_sts;
            irq_en <= next_irq_en;
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            cnt <= next_cnt;
            ovf <= next_ovf;
            half <= next_half;
            prdata_o <= next_prdata;
            pready_o <= next_pready;
            pslverr_o <= next_pslverr;
            core_irq_o <= next_core;
            db_host_irq_o <= next_db_host;
            eng_host_evt_o <= next_eng_host;
            irq_o <= next_irq;
        end
    end

    // FIFO storage, written only on accepted pushes
    always_ff @(posedge clk_sys_i) begin
        for (int k = 0; k < `OCIA_NUM_CSF; k++) begin
            if (push_ok[k]) begin
                csf_mem[k][wr_ptr[k]] <= csf_data_i[k];
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_core_withheld: assert property (!ready |=> core_irq_o == 32'h0000_0000)
        else $error("core interrupt driven before core ready");
    a_core_own_bits: assert property (core_irq_o[3:0] == 4'h0)
        else $error("core-internal interrupt bits driven");
    a_group_on_line: assert property ((ready && irq_sts[`OCIA_GRP_SEM]
        && pin[`OCIA_GRP_SEM] < 5'(`OCIA_NUM_LINES)) |=>
        core_irq_o[$past(pin[`OCIA_GRP_SEM]) + `OCIA_LINE_BASE])
        else $error("mapped group did not reach its line");
    a_unmapped_quiet: assert property ((ready && pin[`OCIA_GRP_HOST_PF] >= 5'(`OCIA_NUM_LINES)
        && (irq_sts & ~(17'h1 << `OCIA_GRP_HOST_PF)) == '0)
        |=> core_irq_o == 32'h0000_0000)
        else $error("unmapped group drove a line");
    a_rung_set: assert property (|db_rung_set_i |=>
        (rung & $past(db_rung_set_i)) == $past(db_rung_set_i))
        else $error("rung flag not set");
    a_rung_hold: assert property ((rung[1] && !db_clr[1]) |=> rung[1])
        else $error("rung flag lost without read");
    a_db_to_host: assert property ((!route && |rung) |=> db_host_irq_o)
        else $error("doorbell not sent to host");
    a_eng_forward: assert property ((eng_evt_i[0][5] && !eng_route[0][5]) |=>
        eng_host_evt_o[0][5] && !$rose(eng_sts[0][5]))
        else $error("engine event not forwarded to host");
    a_dma_done: assert property (dma_done_i |=> dma_iir[0] ##1 irq_sts[`OCIA_GRP_DMA])
        else $error("DMA completion not recorded");
    a_csf_pop: assert property ((rd_acc && !pslverr_o && paddr_i == `OCIA_OFF_CSF_PORT0
        && cnt[0] != 5'h00 && half[0] == OCIA_HALF_HIGH && !csf_push_i[0]) |=>
        cnt[0] == $past(cnt[0]) - 5'h01 && half[0] == OCIA_HALF_LOW)
        else $error("entry not popped after second read");

    c_ready_delivery: cover property (!ready ##1 ready ##1 core_irq_o != 32'h0000_0000);
    c_csf_entry_read: cover property (half[0] == OCIA_HALF_HIGH ##[1:20] half[0] == OCIA_HALF_LOW);
    c_shared_line: cover property (ready && pin[`OCIA_GRP_SEM] == pin[`OCIA_GRP_DISP]
        && pin[`OCIA_GRP_SEM] < 5'(`OCIA_NUM_LINES)
        && (irq_sts[`OCIA_GRP_SEM] || irq_sts[`OCIA_GRP_DISP]));
endmodule // ocia_irq_aggregator
`default_nettype wire

//--- hdl/ocia_pkg.sv
// Types shared by the interrupt aggregator.
// Assumes ocia_consts.svh is on the include path.
`include "ocia_consts.svh"
package ocia_pkg;
    // Half of a 64-bit context-status entry next returned
    typedef enum logic {
        OCIA_HALF_LOW = 1'b0,
        OCIA_HALF_HIGH = 1'b1
    } ocia_half_t;
    // Status word of one context-status FIFO
    typedef struct packed {
        logic overflow;
        logic full;
        logic empty;
        logic [4:0] count;
    } ocia_csf_stat_t;
endpackage

//--- testbench/ocia_core_model.sv
// Model of the embedded core's interrupt input lines.
// Assumes the aggregator's core lines are sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
module ocia_core_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [31:0] core_irq_i,
    output logic [27:0] line_o,
    output logic own_hit_o
);
    // External line n arrives on core bit n+4
    assign line_o = core_irq_i[31:4];
    // Bits 3:0 belong to the core itself; any outside drive is flagged
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            own_hit_o <= 1'b0;
        end else if (core_irq_i[3:0] != 4'h0) begin
            own_hit_o <= 1'b1;
        end
    end
endmodule // ocia_core_model
`default_nettype wire

//--- testbench/test_offload_core_irq_aggregator.sv
// Self-checking bench of the interrupt aggregator.
// Assumes zero-wait APB slave and registered event paths.
`timescale 1ns/1ps
`default_nettype none
module test_offload_core_irq_aggregator;
    import ocia_pkg::*;
    typedef struct packed {
        logic [2:0] ext;
        logic [4:0] grp;
        logic [4:0] line;
        logic [31:0] exp;
    } ocia_row_t;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, db_host, irq, own_hit;
    logic [7:0][31:0] db_bits = '0;
    logic [7:0] db_rung = 8'h00;
    logic [1:0][31:0] eng_evt = '0, eng_host;
    logic dma_done = 1'b0;
    logic [5:0] ext_grp = 6'h00;
    logic [3:0] csf_push = 4'h0;
    logic [3:0][63:0] csf_data = '0;
    logic [31:0] core_irq;
    logic [27:0] line;
    int miscompares = 0, num_checks = 0, n;
    ocia_row_t r;
    ocia_row_t rows [5] = '{'{3'h0, 5'h08, 5'h03, 32'h00000080},
        '{3'h1, 5'h09, 5'h00, 32'h00000010}, '{3'h5, 5'h10, 5'h1B, 32'h80000000},
        '{3'h2, 5'h0D, 5'h1C, 32'h00000000}, '{3'h4, 5'h0F, 5'h1E, 32'h00000000}};
    logic [7:0] pa;

    ocia_irq_aggregator #(.CSF_DEPTH(16)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .db_group_bits_i(db_bits), .db_rung_set_i(db_rung), .eng_evt_i(eng_evt),
        .dma_done_i(dma_done), .ext_grp_i(ext_grp), .csf_push_i(csf_push),
        .csf_data_i(csf_data), .core_irq_o(core_irq), .db_host_irq_o(db_host),
        .eng_host_evt_o(eng_host), .irq_o(irq));
    ocia_core_model core (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .core_irq_i(core_irq),
        .line_o(line), .own_hit_o(own_hit));

    // ****************************************
    // Clock, tasks
    // ****************************************
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
    endtask
    task automatic final_report();
        if (miscompares == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("BAD %0t got %h want %h", $time, got, exp);
            miscompares++;
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            miscompares++;
            final_report();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    function automatic logic [31:0] pin_word(input logic [4:0] g, input logic [4:0] ln);
        logic [31:0] w;
        w = (g[4:2] == 3'h3) ? 32'h1F1F1F00 : 32'h1F1F1F1F;
        w[8*g[1:0] +: 8] = {3'h0, ln};
        return w;
    endfunction

    // Hang guard
    initial begin
        cyc(20000);
        miscompares++;
        final_report();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        cyc(10);
        rst_i <= 1'b0;
        rdc(8'h08, 32'h1F1F1F1F);
        rdc(8'h18, 32'h0000001F);
        rdc(8'h04, 32'h00000000);
        rdc(8'h70, 32'h00000020);
        wr(8'h14, 32'h1F1F1F00);
        dma_done <= 1'b1;
        cyc(1);
        dma_done <= 1'b0;
        cyc(5);
        chk(core_irq, 32'h0);
        rdc(8'h50, 32'h00000001);
        rdc(8'h80, 32'h00001000);
        chk({31'h0, irq}, 32'h0);
        wr(8'h00, 32'h1);
        cyc(4);
        chk({4'h0, line}, 32'h1);
        wr(8'h88, 32'h00001000);
        cyc(3);
        chk({31'h0, irq}, 32'h1);
        wr(8'h50, 32'h1);
        wr(8'h84, 32'h00001000);
        cyc(4);
        chk({31'h0, irq}, 32'h0);
        chk(core_irq, 32'h0);
        // Group-to-line rows
        for (int i = 0; i < 5; i++) begin
            r = rows[i];
            pa = 8'h08 + {3'h0, r.grp[4:2], 2'h0};
            wr(pa, pin_word(r.grp, r.line));
            ext_grp[r.ext] <= 1'b1;
            cyc(4);
            chk(core_irq, r.exp);
            ext_grp[r.ext] <= 1'b0;
            wr(pa, pin_word(r.grp, 5'h1F));
            wr(8'h84, 32'h1 << r.grp);
            cyc(2);
        end
        // Two groups sharing one line, each alone must reach it
        wr(8'h10, 32'h1F1F0505);
        for (int i = 0; i < 2; i++) begin
            ext_grp[i] <= 1'b1;
            cyc(4);
            chk(core_irq, 32'h00000200);
            ext_grp[i] <= 1'b0;
            wr(8'h84, 32'h00000300);
            cyc(4);
        end
        // Doorbell rung flags and routing
        db_bits[2] <= 32'h00008001;
        db_rung[2] <= 1'b1;
        cyc(1);
        db_rung[2] <= 1'b0;
        cyc(3);
        rdc(8'h04, 32'h00000004);
        chk({31'h0, db_host}, 32'h1);
        rdc(8'h04, 32'h00000004);
        rdc(8'h28, 32'h00008001);
        rdc(8'h04, 32'h00000000);
        wr(8'h04, 32'h80000000);
        db_rung[1] <= 1'b1;
        cyc(1);
        db_rung[1] <= 1'b0;
        cyc(3);
        chk({31'h0, db_host}, 32'h0);
        rdc(8'h80, 32'h00000002);
        // Engine events to host, then to core
        eng_evt[0][5] <= 1'b1;
        cyc(1);
        eng_evt[0][5] <= 1'b0;
        n = 0;
        while (eng_host[0][5] !== 1'b1 && n < 8) begin
            cyc(1);
            n++;
        end
        chk({31'h0, eng_host[0][5]}, 32'h1);
        wr(8'h40, 32'h00000020);
        eng_evt[0][5] <= 1'b1;
        cyc(1);
        eng_evt[0][5] <= 1'b0;
        cyc(3);
        rdc(8'h48, 32'h00000020);
        // Context-status entry over two reads
        csf_data[0] <= 64'h89ABCDEF01234567;
        csf_push[0] <= 1'b1;
        cyc(1);
        csf_push[0] <= 1'b0;
        cyc(2);
        rdc(8'h70, 32'h00000001);
        rdc(8'h60, 32'h01234567);
        rdc(8'h60, 32'h89ABCDEF);
        rdc(8'h70, 32'h00000020);
        // Unmapped address
        apb(1'b1, 8'h90, 32'hFFFFFFFF);
        chk({31'h0, rerr}, 32'h1);
        chk({31'h0, own_hit}, 32'h0);
        final_report();
    end
endmodule // test_offload_core_irq_aggregator
`default_nettype wire
